// [serial_link_glue_defines.vh]
`ifndef SERIAL_LINK_GLUE_DEFINES_VH
`define SERIAL_LINK_GLUE_DEFINES_VH

// register byte offsets
`define REG_CONTROL 4'h0
`define REG_STATUS 4'h4
`define REG_STROBE_COUNT 4'h8

// control register fields
`define CTRL_TX_CLK_SEL 0
`define CTRL_RX_REF_LO 1
`define CTRL_RX_REF_HI 2
`define CTRL_OSC_TO_TX_LINE 3
`define CTRL_OSC_TO_REF_LINE 4
`define CTRL_DISABLE_SRC 5
`define CTRL_SELFTEST 6
`define CTRL_WIDTH 7
`define CTRL_RESET 7'h00

// receive reference clock choices
`define RX_REF_EXT_TX 2'h0
`define RX_REF_OSC 2'h1
`define RX_REF_EXT_REF 2'h2

// status register fields
`define STAT_SIGNAL 0
`define STAT_SUPPLY_OK 1
`define STAT_LIGHT_OFF 2
`define STAT_DETECT_POL 3
`define STAT_RESET_OUT_N 4
`define STAT_PERIOD_LO 8

// read strobe low share as a fraction
`define STROBE_LOW_NUM 3
`define STROBE_LOW_DEN 5

// synchronised input bit positions
`define IN_OSC 0
`define IN_EXT_TX 1
`define IN_EXT_REF 2
`define IN_RECOVERED 3
`define IN_TX_ENABLE 4
`define IN_LIGHT_OFF 5
`define IN_SW_DISABLE 6
`define IN_DETECT_POL 7
`define IN_SIGNAL 8
`define IN_SUPPLY_OK 9
`define IN_BUTTON 10
`define IN_SER_P 11
`define IN_SER_N 12
`define IN_COUNT 13

`endif

// [sync_2ff.v]
`timescale 1ns/10ps
module sync_2ff #(
	parameter WIDTH = 1
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// asynchronous side
	input wire [WIDTH-1:0] asyncIn,
	// clock domain side
	output reg [WIDTH-1:0] syncOut
);
	reg [WIDTH-1:0] stage1;

	// first stage feeds only the second
	always @(posedge clk)
	begin
		if (rst)
		begin
			stage1 <= {WIDTH{1'b0}};
			syncOut <= {WIDTH{1'b0}};
		end
		else
		begin
			stage1 <= asyncIn;
			syncOut <= stage1;
		end
	end
endmodule

// [serial_link_glue.v]
// Chosen here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
`include "serial_link_glue_defines.vh"
module serial_link_glue #(
	parameter PERIOD_W = 8,
	parameter LOOP_LEN = 16,
	parameter LOOP_W = 8
) (
	// clock and reset
	input wire clk,
	input wire rst,
	// avalon-mm slave
	input wire [3:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output wire waitrequest,
	// clock pins
	input wire oscIn,
	input wire extTxClockIn,
	output reg extTxClockOut,
	output reg extTxClockOen,
	input wire extRxRefClockIn,
	output reg extRxRefClockOut,
	output reg extRxRefClockOen,
	output reg charWriteClock,
	output reg rxRefClock,
	input wire rxRecoveredClock,
	output reg recoveredClockOut,
	// transmit side
	input wire transmitEnableIn,
	output reg fifoReadStrobe,
	input wire serDataP,
	input wire serDataN,
	output reg serOutP,
	output reg serOutN,
	input wire txLightOff,
	input wire switchTxDisable,
	// status
	input wire detectPolaritySel,
	input wire signalPresent,
	output reg linkStatus,
	input wire supplyOk,
	input wire selftestResetButton,
	output reg resetStatusN
);
	wire [`IN_COUNT-1:0] rawIn;
	wire [`IN_COUNT-1:0] s;
	reg [`CTRL_WIDTH-1:0] control;
	reg ack;
	reg [31:0] strobeCount;
	reg prevCharClock;
	reg [PERIOD_W-1:0] periodCount;
	reg [PERIOD_W-1:0] period;
	reg [PERIOD_W-1:0] lowCount;
	reg [LOOP_W-1:0] loopIndex;
	reg charClockSel;
	reg refClockSel;
	reg disableNow;
	wire charRise;
	wire [PERIOD_W+1:0] lowProduct;
	wire [PERIOD_W+1:0] lowQuotient;
	wire [PERIOD_W-1:0] lowLen;
	wire strobeFire;
	// sized copies of the ratio and loop end, so no compare or divide widens silently
	localparam integer LOW_NUM_INT = `STROBE_LOW_NUM;
	localparam integer LOW_DEN_INT = `STROBE_LOW_DEN;
	localparam integer LOOP_LAST_INT = LOOP_LEN - 1;
	localparam [PERIOD_W+1:0] LOW_NUM = LOW_NUM_INT[PERIOD_W+1:0];
	localparam [PERIOD_W+1:0] LOW_DEN = LOW_DEN_INT[PERIOD_W+1:0];
	localparam [LOOP_W-1:0] LOOP_LAST = LOOP_LAST_INT[LOOP_W-1:0];

	assign rawIn = {serDataN, serDataP, selftestResetButton, supplyOk, signalPresent, detectPolaritySel,
		switchTxDisable, txLightOff, transmitEnableIn, rxRecoveredClock, extRxRefClockIn, extTxClockIn, oscIn};

	// every pin input passes two flops
	sync_2ff #(
		.WIDTH(`IN_COUNT)
	) inSync (
		.clk(clk),
		.rst(rst),
		.asyncIn(rawIn),
		.syncOut(s)
	);

	function [31:0] readMux;
		input [3:0] addr;
		input [`CTRL_WIDTH-1:0] ctrl;
		input [31:0] stat;
		input [31:0] cnt;
		begin
			case (addr)
				`REG_CONTROL: readMux = {{(32-`CTRL_WIDTH){1'b0}}, ctrl};
				`REG_STATUS: readMux = stat;
				`REG_STROBE_COUNT: readMux = cnt;
				default: readMux = 32'h00000000;
			endcase
		end
	endfunction

	// one wait cycle on every access
	assign waitrequest = (read | write) & ~ack;

	wire [31:0] statusWord;
	assign statusWord = {{(24-PERIOD_W){1'b0}}, period, 3'h0, resetStatusN, s[`IN_DETECT_POL], disableNow,
		s[`IN_SUPPLY_OK], s[`IN_SIGNAL]};

	always @(posedge clk)
	begin
		if (rst)
		begin
			ack <= 1'b0;
			readdata <= 32'h00000000;
			control <= `CTRL_RESET;
		end
		else
		begin
			ack <= (read | write) & ~ack;
			if (read && !ack)
				readdata <= readMux(address, control, statusWord, strobeCount);
			// writes land on the edge waitrequest is seen low
			if (write && ack && address == `REG_CONTROL)
				control <= writedata[`CTRL_WIDTH-1:0];
		end
	end

	// clock muxing on sampled levels; selections meant to be static
	always @*
	begin
		charClockSel = control[`CTRL_TX_CLK_SEL] ? s[`IN_OSC] : s[`IN_EXT_TX];
		case (control[`CTRL_RX_REF_HI:`CTRL_RX_REF_LO])
			`RX_REF_EXT_TX: refClockSel = s[`IN_EXT_TX];
			`RX_REF_OSC: refClockSel = s[`IN_OSC];
			`RX_REF_EXT_REF: refClockSel = s[`IN_EXT_REF];
			default: refClockSel = s[`IN_OSC];
		endcase
		disableNow = control[`CTRL_DISABLE_SRC] ? s[`IN_SW_DISABLE] : s[`IN_LIGHT_OFF];
	end

	assign charRise = charClockSel & ~prevCharClock;
	// low share from the measured period, rise to rise so duty cycle does not matter
	assign lowProduct = {2'b00, period} * LOW_NUM;
	assign lowQuotient = lowProduct / LOW_DEN;
	assign lowLen = (lowQuotient[PERIOD_W-1:0] == {PERIOD_W{1'b0}}) ? {{(PERIOD_W-1){1'b0}}, 1'b1}
		: lowQuotient[PERIOD_W-1:0];
	assign strobeFire = control[`CTRL_SELFTEST] ? (charRise && loopIndex == LOOP_LAST)
		: (charRise && s[`IN_TX_ENABLE]);

	always @(posedge clk)
	begin
		if (rst)
		begin
			prevCharClock <= 1'b0;
			periodCount <= {PERIOD_W{1'b0}};
			period <= {PERIOD_W{1'b0}};
			lowCount <= {PERIOD_W{1'b0}};
			loopIndex <= {LOOP_W{1'b0}};
			strobeCount <= 32'h00000000;
			fifoReadStrobe <= 1'b1;
		end
		else
		begin
			prevCharClock <= charClockSel;
			if (charRise)
			begin
				periodCount <= {{(PERIOD_W-1){1'b0}}, 1'b1};
				period <= periodCount;
				if (loopIndex == LOOP_LAST)
					loopIndex <= {LOOP_W{1'b0}};
				else
					loopIndex <= loopIndex + 1'b1;
			end
			else if (periodCount != {PERIOD_W{1'b1}})
				periodCount <= periodCount + 1'b1;
			if (strobeFire)
			begin
				lowCount <= lowLen - 1'b1;
				fifoReadStrobe <= 1'b0;
				strobeCount <= strobeCount + 1'b1;
			end
			else if (lowCount != {PERIOD_W{1'b0}})
				lowCount <= lowCount - 1'b1;
			else
				fifoReadStrobe <= 1'b1;
		end
	end

	// registered pin drivers
	always @(posedge clk)
	begin
		if (rst)
		begin
			serOutP <= 1'b1;
			serOutN <= 1'b0;
			charWriteClock <= 1'b0;
			rxRefClock <= 1'b0;
			extTxClockOut <= 1'b0;
			extTxClockOen <= 1'b1;
			extRxRefClockOut <= 1'b0;
			extRxRefClockOen <= 1'b1;
			recoveredClockOut <= 1'b0;
			linkStatus <= 1'b0;
			resetStatusN <= 1'b0;
		end
		else
		begin
			serOutP <= disableNow ? 1'b1 : s[`IN_SER_P];
			serOutN <= disableNow ? 1'b0 : s[`IN_SER_N];
			charWriteClock <= charClockSel;
			rxRefClock <= refClockSel;
			extTxClockOut <= s[`IN_OSC];
			extTxClockOen <= ~control[`CTRL_OSC_TO_TX_LINE];
			extRxRefClockOut <= s[`IN_OSC];
			extRxRefClockOen <= ~control[`CTRL_OSC_TO_REF_LINE];
			// plain level copy, so a phase jump just passes through
			recoveredClockOut <= s[`IN_RECOVERED];
			linkStatus <= s[`IN_DETECT_POL] ? ~s[`IN_SIGNAL] : s[`IN_SIGNAL];
			resetStatusN <= s[`IN_SUPPLY_OK] & ~s[`IN_BUTTON];
		end
	end
endmodule

// [serial_link_glue_chk.sv]
`timescale 1ns/10ps
module serial_link_glue_chk (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// bus
	input wire logic read,
	input wire logic write,
	input wire logic waitrequest,
	// serial pair and disables
	input wire logic serDataP,
	input wire logic serOutP,
	input wire logic serOutN,
	input wire logic txLightOff,
	input wire logic switchTxDisable,
	// strobe, clocks and status
	input wire logic fifoReadStrobe,
	input wire logic rxRecoveredClock,
	input wire logic recoveredClockOut,
	input wire logic supplyOk,
	input wire logic selftestResetButton,
	input wire logic detectPolaritySel,
	input wire logic signalPresent,
	input wire logic linkStatus,
	input wire logic resetStatusN
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// two sync flops and an output flop: skip four edges after reset
	logic [2:0] up;
	wire ok = up[2];
	always @(posedge clk)
		up <= rst ? 3'h0 : up + {2'h0, !ok};
	a_pair_forced: assert property (ok && $past(txLightOff, 3) && $past(switchTxDisable, 3)
		|-> serOutP && !serOutN) else $error("pair not forced");
	a_pair_follow: assert property (ok && !$past(txLightOff, 3) && !$past(switchTxDisable, 3)
		|-> serOutP == $past(serDataP, 3) && serOutN != serOutP) else $error("pair not following");
	a_link_pol: assert property (ok |-> linkStatus == ($past(signalPresent, 3) ^ $past(detectPolaritySel, 3)))
		else $error("link status wrong");
	a_supply_hold: assert property (ok && !$past(supplyOk, 3) |-> !resetStatusN)
		else $error("reset released early");
	a_button_reset: assert property (ok && $past(selftestResetButton, 3) |-> !resetStatusN)
		else $error("button ignored");
	a_rec_copy: assert property (ok |-> recoveredClockOut == $past(rxRecoveredClock, 3))
		else $error("recovered clock wrong");
	a_strobe_end: assert property ($fell(fifoReadStrobe) |-> ##[1:160] fifoReadStrobe)
		else $error("strobe stuck low");
	a_strobe_high: assert property ($rose(fifoReadStrobe) |-> fifoReadStrobe [*2])
		else $error("strobe high too short");
	a_bus_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
		else $error("second wait cycle");
endmodule
bind serial_link_glue serial_link_glue_chk i_chk (.*);

// [host_test_logic.sv]
`timescale 1ns/10ps
module host_test_logic (
	// from the bench
	input wire logic run,
	input wire logic ena,
	input wire logic skew,
	// connector pins
	output logic hostTx,
	output logic hostRef,
	output logic rxRecoveredClock,
	output logic transmitEnableIn,
	output logic serDataP,
	output logic serDataN
);
	logic sk;
	initial
	begin
		rxRecoveredClock = 0;
		serDataP = 0;
	end
	// stands still outside frames; each period opens on a rise, so skew moves the duty, never the period
	always
	begin
		sk = skew;
		hostTx = run;
		#(sk ? 125 : 80) hostTx = 0;
		#(sk ? 35 : 80);
	end
	always #80 rxRecoveredClock = !rxRecoveredClock;
	always #40 serDataP = !serDataP;
	assign serDataN = !serDataP;
	assign hostRef = rxRecoveredClock;
	assign transmitEnableIn = ena;
endmodule

// [testbench.sv]
`timescale 1ns/10ps
`include "serial_link_glue_defines.vh"
module testbench;
	logic clk = 0, rst = 1, read = 0, write = 0, oscIn = 0, txLightOff = 0, switchTxDisable = 0, run = 0, ena = 0;
	logic skew = 0, detectPolaritySel = 0, signalPresent = 0, supplyOk = 0, selftestResetButton = 0, p1;
	logic [3:0] address = 0;
	logic [31:0] writedata = 0, q;
	wire [31:0] readdata;
	wire waitrequest, extTxClockIn, extTxClockOut, extTxClockOen, extRxRefClockIn, extRxRefClockOut, extRxRefClockOen;
	wire rxRefClock, rxRecoveredClock, transmitEnableIn, fifoReadStrobe, serDataP, serDataN, serOutP, serOutN;
	wire charWriteClock;
	wire linkStatus, resetStatusN, hostTx, hostRef;
	int errTotal = 0, compares = 0, nFall = 0, nRise = 0, lowRun = 0, lastLow = 0, f0, t0, nCw = 0, w0;
	serial_link_glue #(.LOOP_LEN(4)) i_dut (.*, .recoveredClockOut());
	host_test_logic i_host (.*);
	// low enable: the block drives the oscillator onto the line
	assign extTxClockIn = extTxClockOen ? hostTx : extTxClockOut;
	assign extRxRefClockIn = extRxRefClockOen ? hostRef : extRxRefClockOut;
	initial forever #10 clk = !clk;
	initial
	begin
		forever
		begin
			repeat (5) @(posedge clk);
			oscIn <= !oscIn;
		end
	end
	always @(posedge clk)
	begin
		nRise <= nRise + $rose(rxRefClock);
		nFall <= nFall + $fell(fifoReadStrobe);
		nCw <= nCw + $rose(charWriteClock);
		lowRun <= fifoReadStrobe ? 0 : lowRun + 1;
		if (fifoReadStrobe && lowRun > 0)
			lastLow <= lowRun;
	end
	task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			errTotal++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic acc(logic w, logic [3:0] a, logic [31:0] d);
		address <= a;
		writedata <= d;
		write <= w;
		read <= !w;
		// the request stands until the rising edge that shows waitrequest low
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		q = readdata;
		write <= 0;
		read <= 0;
		@(posedge clk);
	endtask
	// windows span whole periods so the counts are exact
	task automatic meas(string nm, int n, int ef, int el);
		f0 = nFall;
		t0 = nRise;
		repeat (n) @(posedge clk);
		cmp(nm, ef, el < 0 ? nRise - t0 : nFall - f0);
		if (el >= 0)
			cmp(nm, el, lastLow);
		$display("test %s done", nm);
	endtask
	task automatic tally_and_finish();
		$display("compares %0d mismatches %0d", compares, errTotal);
		if (errTotal == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		acc(0, `REG_CONTROL, 0);
		cmp("control", 0, q);
		acc(0, 4'hc, 0);
		cmp("unmapped", 0, q);
		acc(0, `REG_STROBE_COUNT, 0);
		cmp("strobe count", 0, q);
		cmp("supply low", 0, resetStatusN);
		supplyOk <= 1;
		repeat (6) @(posedge clk);
		cmp("supply good", 1, resetStatusN);
		selftestResetButton <= 1;
		repeat (6) @(posedge clk);
		cmp("button", 0, resetStatusN);
		selftestResetButton <= 0;
		for (int i = 0; i < 4; i++)
		begin
			{detectPolaritySel, signalPresent} <= i[1:0];
			repeat (6) @(posedge clk);
			cmp("link status", i[0] ^ i[1], linkStatus);
		end
		acc(0, `REG_STATUS, 0);
		cmp("status", 32'h0000001b, q);
		for (int i = 0; i < 8; i++)
		begin
			acc(1, `REG_CONTROL, {i[2], 5'h0});
			{switchTxDisable, txLightOff} <= i[1:0];
			repeat (6) @(posedge clk);
			p1 = serOutP;
			repeat (2) @(posedge clk);
			cmp("pair forced", i[2] ? i[1] : i[0], p1 & serOutP & !serOutN);
		end
		$display("test reset status disable done");
		acc(1, `REG_CONTROL, 0);
		run <= 1;
		ena <= 1;
		// first rises measure against a stale period, so let them pass
		repeat (40) @(posedge clk);
		w0 = nCw;
		meas("strobe ext", 80, 10, 4);
		cmp("char clock ext", 10, nCw - w0);
		skew <= 1;
		repeat (24) @(posedge clk);
		meas("strobe duty", 80, 10, 4);
		ena <= 0;
		repeat (24) @(posedge clk);
		meas("strobe idle", 80, 0, 4);
		acc(1, `REG_CONTROL, 1);
		ena <= 1;
		repeat (40) @(posedge clk);
		w0 = nCw;
		meas("strobe osc", 80, 8, 6);
		cmp("char clock osc", 8, nCw - w0);
		ena <= 0;
		acc(1, `REG_CONTROL, 32'h40);
		repeat (40) @(posedge clk);
		meas("selftest", 128, 4, 4);
		run <= 0;
		for (int i = 0; i < 4; i++)
		begin
			acc(1, `REG_CONTROL, {i[1:0], 1'b0});
			repeat (12) @(posedge clk);
			meas("ref clock", 80, i == 0 ? 0 : (i == 2 ? 10 : 8), -1);
		end
		acc(1, `REG_CONTROL, 32'h18);
		repeat (12) @(posedge clk);
		cmp("oen", 0, {extTxClockOen, extRxRefClockOen});
		meas("osc out", 80, 8, -1);
		acc(1, `REG_CONTROL, 32'h1c);
		repeat (12) @(posedge clk);
		meas("osc ref out", 80, 8, -1);
		tally_and_finish();
	end
	initial
	begin
		#100000;
		errTotal++;
		tally_and_finish();
	end
endmodule
